// ===== core/nvpc_pkg.sv
// shared constants and types of the nonvolatile access block
package nvpc_pkg;
    localparam int CLK_MHZ = 50;

    // access port pages
    localparam logic [7:0] PG_CTRL = 8'h00;
    localparam logic [7:0] PG_DATA_RAM = 8'h01;
    localparam logic [7:0] PG_DEV_PAGE = 8'h02;
    localparam logic [7:0] PG_DEV_RAM = 8'h03;
    localparam logic [7:0] PG_NVM = 8'h04;

    // control page register offsets
    localparam logic [9:0] OFS_PAGE_SEL = 10'h000;
    localparam logic [9:0] OFS_CACHE0 = 10'h001;
    localparam logic [9:0] OFS_NVM_CTRL = 10'h009;
    localparam logic [9:0] OFS_NVM_STAT = 10'h00A;
    localparam logic [9:0] OFS_CRC_CTRL = 10'h00B;
    localparam logic [9:0] OFS_CRC_STAT = 10'h00C;
    localparam logic [9:0] OFS_CRC_VALUE = 10'h00D;
    localparam logic [9:0] OFS_OVERLAY = 10'h00E;
    localparam logic [9:0] OFS_TRACE = 10'h00F;
    localparam logic [9:0] OFS_LOCK = 10'h010;
    localparam logic [9:0] OFS_DBG_LOCK = 10'h011;
    localparam logic [9:0] OFS_MSG_BUF = 10'h012;

    // field positions
    localparam int CTL_ERASE_PROG = 0;
    localparam int CTL_ERASE = 1;
    localparam int CTL_WRITE = 2;
    localparam int ST_ERASE_BUSY = 0;
    localparam int ST_PROG_BUSY = 1;
    localparam int ST_ERASE_DONE = 2;
    localparam int ST_PROG_DONE = 3;
    localparam int CRC_CALC = 0;
    localparam int CRC_RUNNING = 0;
    localparam int CRC_GOOD = 1;
    localparam int TR_EN = 0;
    localparam int TR_SRC = 1;
    localparam int TR_RES24 = 2;
    localparam int TR_EMPTY = 3;
    localparam int TR_HALF = 4;
    localparam int TR_FULL = 5;

    // memory geometry
    localparam int NVM_PAGES = 16;
    localparam int NVM_PAGE_BYTES = 8;
    localparam int NVM_BYTES = 128;
    localparam logic [6:0] NVM_LAST = 7'h7F;
    localparam logic [3:0] NVM_LAST_PAGE = 4'hF;
    localparam logic [7:0] NVM_ERASED = 8'hFF;
    localparam int DATA_RAM_BYTES = 1024;
    localparam int DEV_RAM_WORDS = 2048;
    localparam logic [11:0] TRACE_SAMPLES = 12'h800;
    localparam logic [11:0] TRACE_HALF = 12'h400;

    // reset values
    localparam logic [7:0] CRC_SEED = 8'hFF;
    localparam logic [7:0] LOCK_OPEN = 8'h00;
    localparam logic [7:0] LOCK_CLOSED = 8'hAA;
    localparam logic [7:0] LOCK_RESET = 8'h00;

    // timing
    localparam int CRC_BOOT_US = 340;
    localparam int ERASE_TIME_US = 2;
    localparam int PROG_TIME_US = 2;
    localparam logic [15:0] ERASE_CYC = 16'(ERASE_TIME_US * CLK_MHZ);
    localparam logic [15:0] PROG_CYC = 16'(PROG_TIME_US * CLK_MHZ);

    typedef enum logic [1:0] {SRC_CPU, SRC_HOST, SRC_DEBUG} nvpc_src_e;

    typedef struct packed {
        logic wr;
        logic rd;
        nvpc_src_e src;
        logic [7:0] page;
        logic [9:0] addr;
        logic [7:0] wdata;
    } nvpc_req_s;

    typedef struct packed {
        logic valid;
        logic denied;
        logic [7:0] rdata;
    } nvpc_rsp_s;

    typedef struct packed {
        logic chan;
        logic [23:0] data;
    } nvpc_adc_s;
endpackage

// ===== core/nvpc_crc8_step.sv
// one byte step of the parameter memory checksum
`timescale 1ns/1ns
`default_nettype none
module nvpc_crc8_step (
    input wire logic [7:0] crc,
    input wire logic [7:0] data,
    output logic [7:0] crc_nxt
);
    logic [7:0] x;

    always_comb begin
        x = crc ^ data;
        crc_nxt[0] = x[0] ^ x[6] ^ x[7];
        crc_nxt[1] = x[0] ^ x[1] ^ x[6];
        crc_nxt[2] = x[0] ^ x[1] ^ x[2] ^ x[6];
        crc_nxt[3] = x[1] ^ x[2] ^ x[3] ^ x[7];
        crc_nxt[4] = x[2] ^ x[3] ^ x[4];
        crc_nxt[5] = x[3] ^ x[4] ^ x[5];
        crc_nxt[6] = x[4] ^ x[5] ^ x[6];
        crc_nxt[7] = x[5] ^ x[6] ^ x[7];
    end
endmodule // nvpc_crc8_step
`default_nettype wire

// ===== core/nvpc_buf2.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module nvpc_buf2 #(
    parameter int W = 32
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    typedef struct packed {
        logic [1:0][W-1:0] slot;
        logic [1:0] cnt;
        logic rd;
        logic wr;
    } nvpc_buf_st_s;

    nvpc_buf_st_s st_r;
    nvpc_buf_st_s st_nxt;
    logic push;
    logic pop;

    assign in_ready = (st_r.cnt != 2'd2);
    assign out_valid = (st_r.cnt != 2'd0);
    assign out_data = st_r.slot[st_r.rd];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.slot[st_r.wr] = in_data;
            st_nxt.wr = ~st_r.wr;
        end
        if (pop) begin
            st_nxt.rd = ~st_r.rd;
        end
        st_nxt.cnt = st_r.cnt + 2'(push) - 2'(pop);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule // nvpc_buf2
`default_nettype wire

// ===== core/nvpc_top.sv
// nonvolatile memory sequencer, checksum, RAM mapping, trace and lockout
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - sixteen eight-byte pages, programmed via cache
// - page chosen by upper address bits first
// - combined bit erases then programs page
// - separate erase and program commands accepted
// - erase/program progress readable in status
// - last memory byte holds the checksum
// - programming last byte triggers checksum check
// - calculate bit starts check, running flag
// - crc8 seeded ones, polynomial x8+x2+x+1
// - automatic checksum pass after power-up
// - one-kilobyte data RAM at page one
// - dev RAM overlay or separate range
// - download via page register and page 3
// - trace stores selected channel while enabled
// - stop at 2048 words, right-justified samples
// - empty, half-full, full trace indications
// - trace enabled disables program overlay
// - security refuses host and debugger memory
// - message buffer stays reachable when locked
// - lock code 0x00 opens, 0xAA closes
// - debugger lock bit, resets to zero
module nvpc_top
    import nvpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire nvpc_pkg::nvpc_req_s acc_req,
    output nvpc_pkg::nvpc_rsp_s acc_rsp,
    input wire logic adc_valid,
    output logic adc_ready,
    input wire nvpc_pkg::nvpc_adc_s adc_sample,
    output logic overlay_active,
    output logic dev_ram_separate
);
    import nvpc_pkg::*;

    typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_PROG, OP_CRC} nvpc_op_e;
    typedef struct packed {
        nvpc_op_e op;
        logic [15:0] op_cnt;
        logic chain;
        logic [3:0] page_sel;
        logic [7:0][7:0] cache;
        logic erase_done, prog_done, crc_running;
        logic [6:0] crc_idx;
        logic [7:0] crc_acc, crc_value;
        logic crc_good, overlay_select, trace_en, trace_src, trace_res24;
        logic [11:0] trace_cnt;
        logic [7:0] security_lock_code;
        logic dbg_lock;
        logic [7:0] host_message_buffer;
        logic [4:0] dev_ram_page_select;
        nvpc_rsp_s rsp;
    } nvpc_st_s;
    nvpc_st_s st_r, st_nxt;
    logic [7:0] nvm_mem [NVM_BYTES];
    logic [7:0] data_ram [DATA_RAM_BYTES];
    logic [31:0] dev_ram [DEV_RAM_WORDS];
    logic locked, denied, is_mem, acc_wr, acc_rd, host_dev_wr;
    logic nvm_erase_now, nvm_prog_now, trace_active, trace_write;
    logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
    logic [7:0] crc_step, ctrl_rd;
    logic [12:0] dev_byte;
    logic [31:0] trace_word;
    nvpc_adc_s buf_out;

    nvpc_crc8_step u_crc (
        .crc(st_r.crc_acc),
        .data(nvm_mem[st_r.crc_idx]),
        .crc_nxt(crc_step)
    );

    // only the selected channel enters the buffer
    assign trace_active = st_r.trace_en & (st_r.trace_cnt != TRACE_SAMPLES);
    assign buf_in_valid = adc_valid & trace_active
        & (adc_sample.chan == st_r.trace_src);
    // samples of the other channel are taken and dropped
    assign adc_ready = buf_in_ready | ~buf_in_valid;
    nvpc_buf2 #(.W($bits(nvpc_adc_s))) u_buf (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(adc_sample),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out)
    );
    assign locked = (st_r.security_lock_code == LOCK_CLOSED);
    assign is_mem = (acc_req.page == PG_DATA_RAM)
        || (acc_req.page == PG_DEV_RAM) || (acc_req.page == PG_NVM);
    // host and debugger kept off memories while locked
    // debugger also kept off by its own lock
    // control page, message buffer included, never denied
    assign denied = is_mem && (((acc_req.src == SRC_HOST) && locked)
        || ((acc_req.src == SRC_DEBUG) && (locked || st_r.dbg_lock)));
    // denied writes have no effect at all
    assign acc_wr = acc_req.wr & ~denied;
    assign acc_rd = acc_req.rd & ~denied;
    // selected 256-byte page plus byte offset
    assign dev_byte = {st_r.dev_ram_page_select, acc_req.addr[7:0]};
    assign host_dev_wr = acc_wr && (acc_req.page == PG_DEV_RAM);
    assign trace_word = st_r.trace_res24 ? {8'h00, buf_out.data}
        : {16'h0000, buf_out.data[15:0]};
    // a download write owns the RAM port, so the buffer waits a cycle
    assign buf_out_ready = ~host_dev_wr;
    assign trace_write = buf_out_valid & buf_out_ready & trace_active;
    // trace takes the RAM away from overlay
    assign overlay_active = st_r.overlay_select & ~st_r.trace_en;
    assign dev_ram_separate = ~overlay_active;
    assign acc_rsp = st_r.rsp;
    assign nvm_erase_now = (st_r.op == OP_ERASE) && (st_r.op_cnt == '0);
    assign nvm_prog_now = (st_r.op == OP_PROG) && (st_r.op_cnt == '0);
    always_comb begin
        ctrl_rd = 8'h00;
        case (acc_req.addr)
            OFS_PAGE_SEL: ctrl_rd = {4'h0, st_r.page_sel};
            OFS_NVM_STAT: begin
                ctrl_rd[ST_ERASE_BUSY] = (st_r.op == OP_ERASE);
                ctrl_rd[ST_PROG_BUSY] = (st_r.op == OP_PROG);
                ctrl_rd[ST_ERASE_DONE] = st_r.erase_done;
                ctrl_rd[ST_PROG_DONE] = st_r.prog_done;
            end
            OFS_CRC_STAT: begin
                ctrl_rd[CRC_RUNNING] = st_r.crc_running;
                ctrl_rd[CRC_GOOD] = st_r.crc_good;
            end
            OFS_CRC_VALUE: ctrl_rd = st_r.crc_value;
            OFS_OVERLAY: ctrl_rd = {7'h00, st_r.overlay_select};
            OFS_TRACE: begin
                ctrl_rd[TR_EN] = st_r.trace_en;
                ctrl_rd[TR_SRC] = st_r.trace_src;
                ctrl_rd[TR_RES24] = st_r.trace_res24;
                ctrl_rd[TR_EMPTY] = (st_r.trace_cnt == '0);
                ctrl_rd[TR_HALF] = (st_r.trace_cnt >= TRACE_HALF);
                ctrl_rd[TR_FULL] = (st_r.trace_cnt == TRACE_SAMPLES);
            end
            OFS_LOCK: ctrl_rd = st_r.security_lock_code;
            OFS_DBG_LOCK: ctrl_rd = {7'h00, st_r.dbg_lock};
            OFS_MSG_BUF: ctrl_rd = st_r.host_message_buffer;
            default: begin
                if (acc_req.addr >= OFS_CACHE0
                    && acc_req.addr < OFS_NVM_CTRL) begin
                    ctrl_rd = st_r.cache[3'(acc_req.addr - OFS_CACHE0)];
                end
            end
        endcase
    end
    always_comb begin
        st_nxt = st_r;
        st_nxt.rsp.valid = acc_req.rd;
        st_nxt.rsp.denied = denied & (acc_req.rd | acc_req.wr);
        st_nxt.rsp.rdata = 8'h00;
        if (acc_rd) begin
            case (acc_req.page)
                PG_CTRL: st_nxt.rsp.rdata = ctrl_rd;
                PG_DATA_RAM: st_nxt.rsp.rdata = data_ram[acc_req.addr];
                PG_DEV_PAGE: st_nxt.rsp.rdata = {3'h0, st_r.dev_ram_page_select};
                PG_DEV_RAM: st_nxt.rsp.rdata =
                    dev_ram[dev_byte[12:2]][8*dev_byte[1:0] +: 8];
                PG_NVM: st_nxt.rsp.rdata = nvm_mem[acc_req.addr[6:0]];
                default: st_nxt.rsp.rdata = 8'h00;
            endcase
        end
        if (trace_write) begin
            st_nxt.trace_cnt = st_r.trace_cnt + 12'd1;
        end
        // page operation sequencer
        case (st_r.op)
            OP_ERASE: begin
                st_nxt.op_cnt = st_r.op_cnt - 16'd1;
                if (nvm_erase_now) begin
                    st_nxt.erase_done = 1'b1;
                    st_nxt.op = st_r.chain ? OP_PROG : OP_IDLE;
                    st_nxt.op_cnt = PROG_CYC - 16'd1;
                end
            end
            OP_PROG: begin
                st_nxt.op_cnt = st_r.op_cnt - 16'd1;
                if (nvm_prog_now) begin
                    st_nxt.prog_done = 1'b1;
                    st_nxt.chain = 1'b0;
                    st_nxt.op = OP_IDLE;
                    // last page written, check the checksum
                    if (st_r.page_sel == NVM_LAST_PAGE) begin
                        st_nxt.op = OP_CRC;
                        st_nxt.crc_running = 1'b1;
                        st_nxt.crc_idx = '0;
                        st_nxt.crc_acc = CRC_SEED;
                    end
                end
            end
            OP_CRC: begin
                // data bytes only, the last byte is the reference
                st_nxt.crc_acc = crc_step;
                st_nxt.crc_idx = st_r.crc_idx + 7'd1;
                if (st_r.crc_idx == NVM_LAST - 7'd1) begin
                    st_nxt.op = OP_IDLE;
                    st_nxt.crc_running = 1'b0;
                    st_nxt.crc_value = crc_step;
                    st_nxt.crc_good = (crc_step == nvm_mem[NVM_LAST]);
                end
            end
            default: st_nxt.op = OP_IDLE;
        endcase
        if (acc_wr) begin
            case (acc_req.page)
                PG_CTRL: begin
                    case (acc_req.addr)
                        // page select from data bits 3..0, used as memory address bits 6..3
                        OFS_PAGE_SEL: st_nxt.page_sel = acc_req.wdata[3:0];
                        OFS_NVM_CTRL: begin
                            // commands while busy are ignored
                            if (st_r.op == OP_IDLE) begin
                                if (acc_req.wdata[CTL_ERASE_PROG]
                                    || acc_req.wdata[CTL_ERASE]) begin
                                    st_nxt.op = OP_ERASE;
                                    st_nxt.op_cnt = ERASE_CYC - 16'd1;
                                    st_nxt.chain =
                                        acc_req.wdata[CTL_ERASE_PROG];
                                    st_nxt.erase_done = 1'b0;
                                    st_nxt.prog_done = 1'b0;
                                end else if (acc_req.wdata[CTL_WRITE]) begin
                                    st_nxt.op = OP_PROG;
                                    st_nxt.op_cnt = PROG_CYC - 16'd1;
                                    st_nxt.prog_done = 1'b0;
                                end
                            end
                        end
                        OFS_CRC_CTRL: begin
                            if (acc_req.wdata[CRC_CALC]
                                && st_r.op == OP_IDLE) begin
                                st_nxt.op = OP_CRC;
                                st_nxt.crc_running = 1'b1;
                                st_nxt.crc_idx = '0;
                                st_nxt.crc_acc = CRC_SEED;
                            end
                        end
                        OFS_OVERLAY: st_nxt.overlay_select = acc_req.wdata[0];
                        OFS_TRACE: begin
                            // a fresh enable restarts the capture
                            if (acc_req.wdata[TR_EN] && !st_r.trace_en) begin
                                st_nxt.trace_cnt = '0;
                            end
                            st_nxt.trace_en = acc_req.wdata[TR_EN];
                            st_nxt.trace_src = acc_req.wdata[TR_SRC];
                            st_nxt.trace_res24 = acc_req.wdata[TR_RES24];
                        end
                        // other codes leave the lock as it is
                        OFS_LOCK: begin
                            if (acc_req.wdata == LOCK_OPEN
                                || acc_req.wdata == LOCK_CLOSED) begin
                                st_nxt.security_lock_code = acc_req.wdata;
                            end
                        end
                        OFS_DBG_LOCK: st_nxt.dbg_lock = acc_req.wdata[0];
                        OFS_MSG_BUF: st_nxt.host_message_buffer = acc_req.wdata;
                        default: begin
                            // each cache byte loaded by the host
                            if (acc_req.addr >= OFS_CACHE0
                                && acc_req.addr < OFS_NVM_CTRL) begin
                                st_nxt.cache[3'(acc_req.addr - OFS_CACHE0)] =
                                    acc_req.wdata;
                            end
                        end
                    endcase
                end
                PG_DEV_PAGE: st_nxt.dev_ram_page_select = acc_req.wdata[4:0];
                default: st_nxt.dev_ram_page_select = st_r.dev_ram_page_select;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r <= '0;
            // automatic checksum pass out of reset
            st_r.op <= OP_CRC;
            st_r.crc_running <= 1'b1;
            st_r.crc_acc <= CRC_SEED;
            st_r.security_lock_code <= LOCK_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        for (int i = 0; i < NVM_PAGE_BYTES; i++) begin
            if (nvm_erase_now) begin
                nvm_mem[{st_r.page_sel, 3'(i)}] <= NVM_ERASED;
            end else if (nvm_prog_now) begin
                nvm_mem[{st_r.page_sel, 3'(i)}] <= st_r.cache[i];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (acc_wr && acc_req.page == PG_DATA_RAM) begin
            data_ram[acc_req.addr] <= acc_req.wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        // byte download into the selected page
        if (host_dev_wr) begin
            dev_ram[dev_byte[12:2]][8*dev_byte[1:0] +: 8] <= acc_req.wdata;
        // one word per sample, capped at 2048
        end else if (trace_write) begin
            dev_ram[st_r.trace_cnt[10:0]] <= trace_word;
        end
    end
endmodule // nvpc_top
`default_nettype wire

// ===== tb/nvpc_props.sv
// port assertions of the nonvolatile access block
`timescale 1ns/1ns
`default_nettype none
module nvpc_props
    import nvpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire nvpc_pkg::nvpc_req_s acc_req,
    input wire nvpc_pkg::nvpc_rsp_s acc_rsp,
    input wire logic adc_valid,
    input wire logic adc_ready,
    input wire nvpc_pkg::nvpc_adc_s adc_sample,
    input wire logic overlay_active,
    input wire logic dev_ram_separate
);
    logic lk_r;
    logic tr_r;
    wire c0 = acc_req.wr && acc_req.page == PG_CTRL;
    wire hr = acc_req.rd && acc_req.src == SRC_HOST;
    wire hw = acc_req.wr && acc_req.src == SRC_HOST;
    // lock and trace shadows, page 0 never refused
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lk_r <= 1'b0;
            tr_r <= 1'b0;
        end else if (c0 && acc_req.addr == OFS_LOCK) begin
            if (acc_req.wdata == LOCK_CLOSED) lk_r <= 1'b1;
            if (acc_req.wdata == LOCK_OPEN) lk_r <= 1'b0;
        end else if (c0 && acc_req.addr == OFS_TRACE) begin
            tr_r <= acc_req.wdata[TR_EN];
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_rd_answer: assert property (acc_req.rd |=> acc_rsp.valid)
        else $error("read without answer");
    chk_lock_deny: assert property (
        hr && acc_req.page == PG_NVM && lk_r
        |=> acc_rsp.denied && acc_rsp.rdata == 8'h00)
        else $error("locked read not refused");
    chk_lock_open: assert property (
        hr && acc_req.page == PG_NVM && !lk_r |=> !acc_rsp.denied)
        else $error("open read refused");
    chk_wr_drop: assert property (
        hw && acc_req.page == PG_DATA_RAM && lk_r
        |=> acc_rsp.denied && !acc_rsp.valid)
        else $error("locked write not refused");
    chk_ctrl_open: assert property (
        acc_req.rd && acc_req.page == PG_CTRL |=> !acc_rsp.denied)
        else $error("control page refused");
    chk_cpu_free: assert property (
        (acc_req.rd || acc_req.wr) && acc_req.src == SRC_CPU
        |=> !acc_rsp.denied)
        else $error("cpu access refused");
    chk_deny_zero: assert property (
        acc_rsp.denied && acc_rsp.valid |-> acc_rsp.rdata == 8'h00)
        else $error("refused read data not zero");
    chk_overlay_pair: assert property (
        overlay_active != dev_ram_separate)
        else $error("overlay and separate agree");
    chk_trace_overlay: assert property (tr_r |-> !overlay_active)
        else $error("overlay during trace");
    cov_locked: cover property (hr && lk_r && acc_req.page == PG_NVM);
    cov_trace: cover property (tr_r && adc_valid && adc_ready);
    cov_overlay: cover property (overlay_active);
endmodule // nvpc_props
bind nvpc_top nvpc_props nvpc_props_i (.core_clk(core_clk), .rst(rst),
    .acc_req(acc_req), .acc_rsp(acc_rsp), .adc_valid(adc_valid),
    .adc_ready(adc_ready), .adc_sample(adc_sample),
    .overlay_active(overlay_active), .dev_ram_separate(dev_ram_separate));
`default_nettype wire

// ===== tb/nvpc_adc_src.sv
// converter stand-in feeding samples to the trace path
`timescale 1ns/1ns
`default_nettype none
module nvpc_adc_src
    import nvpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic go,
    input wire logic adc_ready,
    output logic adc_valid,
    output nvpc_pkg::nvpc_adc_s adc_sample,
    output logic done
);
    // offer held until the edge that sees ready
    task automatic push(input logic ch, input logic [23:0] v);
        adc_sample = {ch, v};
        adc_valid = 1'b1;
        do @(posedge core_clk); while (!adc_ready);
        @(negedge core_clk);
    endtask
    initial begin
        adc_valid = 1'b0;
        adc_sample = '0;
        done = 1'b0;
        wait (go);
        @(negedge core_clk);
        for (int k = 0; k < 2100; k++) begin
            push(1'b0, 24'hC3_0000 | 24'(k));
            push(1'b1, 24'hEE_EEEE);
            // idle gap scrambles the data lines
            if (k % 5 == 0) begin
                adc_valid = 1'b0;
                adc_sample = ~adc_sample;
                @(negedge core_clk);
            end
        end
        adc_valid = 1'b0;
        done = 1'b1;
    end
endmodule // nvpc_adc_src
`default_nettype wire

// ===== tb/nvpc_tb_top.sv
// self-checking bench of the nonvolatile access block
`timescale 1ns/1ns
`default_nettype none
module nvpc_tb_top;
    import nvpc_pkg::*;
    logic core_clk = 1'b0;
    logic go = 1'b0;
    logic rst, done, adc_valid, adc_ready, ov, sep, dn;
    logic [7:0] d, cr;
    logic [7:0] img [128];
    nvpc_req_s q;
    nvpc_rsp_s acc_rsp;
    nvpc_adc_s smp;
    int n_errors = 0, n_checks = 0;
    always #10 core_clk = ~core_clk;
    nvpc_top nvpc_top_i (.core_clk(core_clk), .rst(rst), .acc_req(q),
        .acc_rsp(acc_rsp), .adc_valid(adc_valid), .adc_ready(adc_ready),
        .adc_sample(smp), .overlay_active(ov), .dev_ram_separate(sep));
    nvpc_adc_src nvpc_adc_src_i (.core_clk(core_clk), .go(go),
        .adc_ready(adc_ready), .adc_valid(adc_valid), .adc_sample(smp),
        .done(done));
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] s, e);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] p, input logic [9:0] a,
        input logic [7:0] v, input nvpc_src_e s = SRC_HOST);
        q = '{1'b1, 1'b0, s, p, a, v};
        @(negedge core_clk);
        q.wr = 1'b0;
        @(negedge core_clk);
    endtask
    task automatic rd(input logic [7:0] p, input logic [9:0] a,
        input nvpc_src_e s = SRC_HOST);
        q = '{1'b0, 1'b1, s, p, a, 8'h00};
        @(negedge core_clk);
        q.rd = 1'b0;
        d = acc_rsp.rdata;
        dn = acc_rsp.denied;
        @(negedge core_clk);
    endtask
    task automatic poll(input logic [9:0] a, input int b, input logic v);
        int n = 0;
        do begin
            rd(PG_CTRL, a);
            n++;
        end while (d[b] !== v && n < 400);
        chk("status bit", {7'h00, d[b]}, {7'h00, v});
    endtask
    task automatic prog(input int p);
        wr(PG_CTRL, OFS_PAGE_SEL, 8'(p));
        for (int i = 0; i < 8; i++)
            wr(PG_CTRL, OFS_CACHE0 + 10'(i), img[8 * p + i]);
        wr(PG_CTRL, OFS_NVM_CTRL, 8'h01);
        poll(OFS_NVM_STAT, ST_PROG_DONE, 1'b1);
    endtask
    initial begin
        #1000000;
        n_errors++;
        close_out;
    end
    initial begin
        q = '0;
        rst = 1'b1;
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        poll(OFS_CRC_STAT, CRC_RUNNING, 1'b0);
        rd(PG_CTRL, OFS_LOCK);
        chk("lock reset", d, LOCK_RESET);
        rd(PG_CTRL, OFS_DBG_LOCK);
        chk("debug lock reset", d, 8'h00);
        cr = CRC_SEED;
        for (int i = 0; i < 127; i++) begin
            img[i] = 8'(i) ^ 8'h5A;
            for (int j = 7; j >= 0; j--)
                cr = {cr[6:0], 1'b0} ^ ((cr[7] ^ img[i][j]) ? 8'h07 : 8'h00);
        end
        img[127] = cr;
        for (int p = 0; p < 16; p++) prog(p);
        poll(OFS_CRC_STAT, CRC_RUNNING, 1'b0);
        poll(OFS_CRC_STAT, CRC_GOOD, 1'b1);
        rd(PG_CTRL, OFS_CRC_VALUE);
        chk("crc value", d, cr);
        for (int i = 0; i < 128; i++) begin
            rd(PG_NVM, 10'(i));
            chk("nvm byte", d, img[i]);
        end
        wr(PG_CTRL, OFS_NVM_CTRL, 8'h02);
        poll(OFS_NVM_STAT, ST_ERASE_DONE, 1'b1);
        rd(PG_NVM, 10'h07F);
        chk("erased byte", d, NVM_ERASED);
        wr(PG_CTRL, OFS_CRC_CTRL, 8'h01);
        poll(OFS_CRC_STAT, CRC_RUNNING, 1'b0);
        chk("crc bad", {7'h00, d[CRC_GOOD]}, 8'h00);
        wr(PG_CTRL, OFS_NVM_CTRL, 8'h04);
        poll(OFS_NVM_STAT, ST_PROG_DONE, 1'b1);
        poll(OFS_CRC_STAT, CRC_RUNNING, 1'b0);
        chk("crc good", {7'h00, d[CRC_GOOD]}, 8'h01);
        wr(PG_DATA_RAM, 10'h005, 8'h77, SRC_CPU);
        wr(PG_CTRL, OFS_LOCK, LOCK_CLOSED);
        rd(PG_NVM, 10'h07F);
        chk("locked data", d, 8'h00);
        chk("locked refused", {7'h00, dn}, 8'h01);
        wr(PG_DATA_RAM, 10'h005, 8'h11);
        wr(PG_CTRL, OFS_MSG_BUF, 8'h3C);
        rd(PG_CTRL, OFS_MSG_BUF);
        chk("message buffer", d, 8'h3C);
        rd(PG_NVM, 10'h07F, SRC_CPU);
        chk("cpu read", d, cr);
        wr(PG_CTRL, OFS_LOCK, LOCK_OPEN);
        rd(PG_DATA_RAM, 10'h005);
        chk("ram kept", d, 8'h77);
        wr(PG_CTRL, OFS_DBG_LOCK, 8'h01);
        rd(PG_NVM, 10'h07F, SRC_DEBUG);
        chk("debug refused", {7'h00, dn}, 8'h01);
        rd(PG_NVM, 10'h07F);
        chk("host open", d, cr);
        wr(PG_CTRL, OFS_OVERLAY, 8'h01);
        chk("overlay on", {7'h00, ov}, 8'h01);
        wr(PG_CTRL, OFS_TRACE, 8'h05);
        chk("overlay off", {7'h00, ov}, 8'h00);
        go = 1'b1;
        for (int n = 0; n < 9000 && !done; n++) @(negedge core_clk);
        repeat (8) @(negedge core_clk);
        rd(PG_CTRL, OFS_TRACE);
        chk("trace flags", d & 8'h38, 8'h30);
        wr(PG_DEV_PAGE, 10'h000, 8'h00);
        rd(PG_DEV_RAM, 10'h002);
        chk("word0 top", d, 8'hC3);
        rd(PG_DEV_RAM, 10'h003);
        chk("word0 pad", d, 8'h00);
        rd(PG_DEV_RAM, 10'h004);
        chk("word1 low", d, 8'h01);
        wr(PG_DEV_PAGE, 10'h000, 8'h1F);
        rd(PG_DEV_RAM, 10'h0FD);
        chk("last word", d, 8'h07);
        wr(PG_CTRL, OFS_TRACE, 8'h00);
        wr(PG_CTRL, OFS_OVERLAY, 8'h00);
        chk("separate", {7'h00, sep}, 8'h01);
        wr(PG_DEV_PAGE, 10'h000, 8'h05);
        wr(PG_DEV_RAM, 10'h011, 8'hA5);
        rd(PG_DEV_RAM, 10'h011);
        chk("download", d, 8'hA5);
        close_out;
    end
endmodule // nvpc_tb_top
`default_nettype wire
